// ### hw/rtc_cfg.svh
// constants for the remote temperature conversion sequencer
// assumes a 10 MHz system clock; included by the sequencer file only
`ifndef RTC_CFG_SVH
`define RTC_CFG_SVH

`define RTC_CLK_HZ 10000000
`define RTC_PERIOD_MS 250
`define RTC_INTEG_MS 60
`define RTC_PERIOD_CYC ((`RTC_CLK_HZ / 1000) * `RTC_PERIOD_MS)
`define RTC_INTEG_CYC ((`RTC_CLK_HZ / 1000) * `RTC_INTEG_MS)

`define RTC_OFF_CONFIG 12'h000
`define RTC_OFF_MODE 12'h004
`define RTC_OFF_ONESHOT 12'h008
`define RTC_OFF_TEMP 12'h00C
`define RTC_OFF_STATUS 12'h010
`define RTC_OFF_ADC_RAW 12'h014

`define RTC_CFG_STOP_BIT 6
`define RTC_MODE_TLOOP_BIT 0
`define RTC_MODE_FLOOP_BIT 1
`define RTC_MODE_TRIM_LSB 2
`define RTC_MODE_TRIM_MSB 5

`define RTC_CONFIG_RST 8'h00
`define RTC_MODE_RST 8'h00
`define RTC_TEMP_RST 11'h000

`endif

// ### hw/rtc_pkg.sv
// types shared by the conversion sequencer files
// no assumptions beyond a SystemVerilog package scope
package rtc_pkg;
  typedef enum logic [1:0] {
    RTC_IDLE = 2'b00,
    RTC_INTEG = 2'b01,
    RTC_DONE = 2'b10
  } rtc_state_t;
  typedef logic [10:0] rtc_temp_t;
endpackage

// ### hw/rtc_cnt.sv
// free counter with synchronous restart and terminal flag
// assumes the caller restarts it when its interval must begin anew
`timescale 1ns/1ps
`default_nettype none
module rtc_cnt #(
  parameter int unsigned LIMIT = 16,
  parameter int unsigned W = 24
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic clear_i,
  input wire logic run_i,
  output logic done_o
);
  logic [W-1:0] count_r;
  wire logic at_end = (count_r == W'(LIMIT - 1));

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      count_r <= '0;
    else if (clear_i || !run_i || at_end)
      count_r <= '0;
    else
      count_r <= count_r + W'(1);
  end

  assign done_o = run_i && !clear_i && at_end;
endmodule
`default_nettype wire

// ### hw/rtc_sync.sv
// two-flop synchroniser for a level from outside the clock domain
// assumes the level is slow compared with the clock
`timescale 1ns/1ps
`default_nettype none
module rtc_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic d_i,
  output logic q_o
);
  logic meta_r;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_r <= RST_VAL;
      q_o <= RST_VAL;
    end
    else
    begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ### hw/rtc_seq.sv
// remote temperature conversion sequencer with apb register slave
// assumes an external integrating adc that accepts a gain trim and returns
// an 11-bit signed result when the integration window closes
//
// Behaviour
// RULE1 - result is 11-bit two's complement, lsb one eighth degree
// RULE2 - free-running mode starts a conversion every 250 ms
// RULE3 - config bit 6 clear enables periodic conversions, set disables them
// RULE4 - a single-shot write starts a conversion at once
// RULE5 - old result stays readable until the new conversion completes
// RULE6 - each measurement integrates for 60 ms
// RULE7 - each result goes to fan regulator and readable register
// RULE8 - mode bits 5 to 2 form the adc gain trim
// RULE9 - software can open thermal loop and fan loop separately
// RULE10 - standby during conversion aborts it, results keep old value
// RULE11 - single-shot works in software standby, ignored with standby pin low
// RULE12 - interval counter restarts when periodic mode is re-enabled
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_cfg.svh"
module rtc_seq #(
  parameter int unsigned PERIOD_CYC = `RTC_PERIOD_CYC,
  parameter int unsigned INTEG_CYC = `RTC_INTEG_CYC
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic standby_pin_n_i,
  input wire rtc_pkg::rtc_temp_t adc_result_i,
  output logic adc_integrate_o,
  output logic [3:0] adc_gain_trim_o,
  output rtc_pkg::rtc_temp_t fan_temp_o,
  output logic fan_temp_valid_o,
  output logic thermal_loop_open_o,
  output logic fan_loop_open_o
);
  import rtc_pkg::*;

  // ---------------------------------------------------------------
  // reset release and pin synchronisation
  // ---------------------------------------------------------------
  logic rst_meta_r;
  logic rst_n_r;

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  logic standby_pin_n_pin_n_s;

  // pin resets high so a board without the pin is not in standby
  rtc_sync #(
    .RST_VAL(1'b1)
  ) u_standby_pin_n_sync (
    .clk_i(clk_sys_i),
    .rst_n_i(rst_n_r),
    .d_i(standby_pin_n_i),
    .q_o(standby_pin_n_pin_n_s)
  );

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  logic [7:0] config_r;
  logic [7:0] mode_r;
  rtc_temp_t temp_r;
  rtc_temp_t raw_r;
  rtc_state_t state_r;
  rtc_state_t state_nxt;

  // single-cycle access: pready is high in every access phase
  wire logic access = psel_i && penable_i;
  wire logic wr_acc = access && pwrite_i;
  wire logic sel_config = (paddr_i == `RTC_OFF_CONFIG);
  wire logic sel_mode = (paddr_i == `RTC_OFF_MODE);
  wire logic sel_oneshot = (paddr_i == `RTC_OFF_ONESHOT);
  wire logic sel_temp = (paddr_i == `RTC_OFF_TEMP);
  wire logic sel_status = (paddr_i == `RTC_OFF_STATUS);
  wire logic sel_raw = (paddr_i == `RTC_OFF_ADC_RAW);
  wire logic mapped = sel_config || sel_mode || sel_oneshot || sel_temp || sel_status || sel_raw;
  wire logic wr_config = wr_acc && sel_config && pstrb_i[0];
  wire logic wr_mode = wr_acc && sel_mode && pstrb_i[0];
  wire logic wr_oneshot = wr_acc && sel_oneshot;
  // read-only registers refuse writes as well as unmapped addresses
  wire logic bad_acc = access && (!mapped || (pwrite_i && (sel_temp || sel_status || sel_raw)));

  // status: bit 2 pin standby, bits 1:0 sequencer state
  wire logic [31:0] status_word = {29'h0000000, !standby_pin_n_pin_n_s, state_r};
  wire logic [31:0] rd_word =
    sel_config ? {24'h000000, config_r} :
    sel_mode ? {24'h000000, mode_r} :
    sel_temp ? {{21{temp_r[10]}}, temp_r} :
    sel_status ? status_word :
    sel_raw ? {21'h000000, raw_r} :
    32'h00000000;

  // ---------------------------------------------------------------
  // apb response
  // ---------------------------------------------------------------
  // the answer is decoded in the setup cycle and registered, so pready,
  // pslverr and read data all stand together in the access cycle
  wire logic setup_cyc = psel_i && !penable_i;
  wire logic rd_setup = setup_cyc && !pwrite_i;
  // a read-only register written still counts as an error
  wire logic mapped_setup = mapped && !(pwrite_i && (sel_temp || sel_status || sel_raw));

  always_ff @(posedge clk_sys_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      prdata_o <= 32'h00000000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end
    else
    begin
      pready_o <= setup_cyc;
      pslverr_o <= setup_cyc && !mapped_setup;
      prdata_o <= rd_setup ? rd_word : prdata_o;
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
      config_r <= `RTC_CONFIG_RST;
    else if (wr_config && pready_o && !bad_acc)
      config_r <= pwdata_i[7:0];
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
      mode_r <= `RTC_MODE_RST;
    else if (wr_mode && pready_o && !bad_acc)
      mode_r <= pwdata_i[7:0];
  end

  // ---------------------------------------------------------------
  // scheduling
  // ---------------------------------------------------------------
  // RULE3 periodic enable bit
  wire logic sw_stop = config_r[`RTC_CFG_STOP_BIT];
  wire logic hw_standby_pin_n = !standby_pin_n_pin_n_s;
  wire logic periodic_en = !sw_stop && !hw_standby_pin_n;
  logic periodic_en_q_r;
  // RULE12 restart on re-enable
  wire logic periodic_restart = periodic_en && !periodic_en_q_r;
  logic tick;

  // 24 bits hold the full interval count; it keeps running through a
  // conversion so the spacing is measured from start to start
  // RULE2 250 ms interval
  rtc_cnt #(
    .LIMIT(PERIOD_CYC),
    .W(24)
  ) u_period (
    .clk_i(clk_sys_i),
    .rst_n_i(rst_n_r),
    .clear_i(periodic_restart),
    .run_i(periodic_en),
    .done_o(tick)
  );

  // RULE4 single-shot start
  // RULE11 pin standby blocks one-shot
  wire logic oneshot_go = wr_oneshot && pready_o && !hw_standby_pin_n;
  logic oneshot_run_r;
  // RULE10 abort on standby
  // software stop spares a one-shot, otherwise standby could never sample
  wire logic abort = (state_r == RTC_INTEG) && (hw_standby_pin_n || (sw_stop && !oneshot_run_r));
  // starts that arrive while busy are dropped: only idle accepts one
  wire logic start = tick || oneshot_go;
  logic integ_done;

  // RULE6 60 ms window
  rtc_cnt #(
    .LIMIT(INTEG_CYC),
    .W(24)
  ) u_integ (
    .clk_i(clk_sys_i),
    .rst_n_i(rst_n_r),
    .clear_i(1'b0),
    .run_i(state_r == RTC_INTEG && !abort),
    .done_o(integ_done)
  );

  // ---------------------------------------------------------------
  // conversion state machine
  // ---------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      RTC_IDLE:
      begin
        if (start)
          state_nxt = RTC_INTEG;
      end
      RTC_INTEG:
      begin
        if (abort)
          state_nxt = RTC_IDLE;
        else if (integ_done)
          state_nxt = RTC_DONE;
      end
      RTC_DONE:
        state_nxt = RTC_IDLE;
      default:
        state_nxt = RTC_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      state_r <= RTC_IDLE;
      periodic_en_q_r <= 1'b0;
      oneshot_run_r <= 1'b0;
      raw_r <= `RTC_TEMP_RST;
    end
    else
    begin
      state_r <= state_nxt;
      periodic_en_q_r <= periodic_en;
      if (state_r == RTC_IDLE && start)
        oneshot_run_r <= oneshot_go;
      if (integ_done)
        raw_r <= adc_result_i;
    end
  end

  // ---------------------------------------------------------------
  // result publishing
  // ---------------------------------------------------------------
  // RULE5 update only at end
  // RULE1 signed eighth-degree word
  // RULE7 register and fan path
  always_ff @(posedge clk_sys_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      temp_r <= `RTC_TEMP_RST;
      fan_temp_o <= `RTC_TEMP_RST;
      fan_temp_valid_o <= 1'b0;
    end
    else
    begin
      // strobe rises with the new word so the regulator never sees stale data
      fan_temp_valid_o <= (state_r == RTC_DONE);
      if (state_r == RTC_DONE)
      begin
        temp_r <= raw_r;
        fan_temp_o <= raw_r;
      end
    end
  end

  // mode fields decoded once so the output flops stay plain copies
  wire logic [3:0] trim_field = mode_r[`RTC_MODE_TRIM_MSB:`RTC_MODE_TRIM_LSB];
  wire logic tloop_open = mode_r[`RTC_MODE_TLOOP_BIT];
  wire logic floop_open = mode_r[`RTC_MODE_FLOOP_BIT];

  // RULE8 gain trim field
  // RULE9 loop open controls
  always_ff @(posedge clk_sys_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      adc_integrate_o <= 1'b0;
      adc_gain_trim_o <= 4'h0;
      thermal_loop_open_o <= 1'b0;
      fan_loop_open_o <= 1'b0;
    end
    else
    begin
      adc_integrate_o <= (state_nxt == RTC_INTEG);
      adc_gain_trim_o <= trim_field;
      thermal_loop_open_o <= tloop_open;
      fan_loop_open_o <= floop_open;
    end
  end
endmodule
`default_nettype wire

// ### testbench/rtc_seq_chk.sv
// port checker for the conversion sequencer, bound below
// assumes the sequencer top ports and its one-clock timing
`timescale 1ns/1ps
`default_nettype none
module rtc_seq_chk #(
  parameter int PERIOD_CYC = 40,
  parameter int INTEG_CYC = 10
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic standby_pin_n_i,
  input wire rtc_pkg::rtc_temp_t fan_temp_o,
  input wire logic fan_temp_valid_o,
  input wire logic adc_integrate_o,
  input wire logic [3:0] adc_gain_trim_o,
  input wire logic thermal_loop_open_o,
  input wire logic fan_loop_open_o
);
  import rtc_pkg::*;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  // ------
  // window length and write decode
  // ------
  wire logic acc = psel_i && penable_i && pready_o;
  wire logic mode_wr = acc && pwrite_i && paddr_i == 12'h004;
  wire logic shot_wr = acc && pwrite_i && paddr_i == 12'h008;
  logic [23:0] run_r;
  logic [23:0] last_r;
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      run_r <= 24'h000000;
      last_r <= 24'h000000;
    end
    else
    begin
      run_r <= adc_integrate_o ? run_r + 24'h000001 : 24'h000000;
      last_r <= adc_integrate_o ? run_r + 24'h000001 : last_r;
    end
  end
  a_integ_bound: assert property (run_r <= 24'(INTEG_CYC))
    else $error("integration window too long");
  a_integ_full: assert property ($rose(fan_temp_valid_o) |-> last_r == 24'(INTEG_CYC))
    else $error("result from a short window");
  a_valid_pulse: assert property (fan_temp_valid_o |=> !fan_temp_valid_o)
    else $error("result strobe too long");
  a_result_hold: assert property (!$stable(fan_temp_o) |-> fan_temp_valid_o)
    else $error("result changed without strobe");
  a_temp_sign: assert property (acc && !pwrite_i && paddr_i == 12'h00C |->
      prdata_o[31:11] == {21{prdata_o[10]}})
    else $error("result read not sign extended");
  a_mode_hold: assert property (!$stable({adc_gain_trim_o, fan_loop_open_o,
      thermal_loop_open_o}) |-> $past(mode_wr) || $past(mode_wr, 2))
    else $error("trim or loop output moved without a write");
  a_oneshot_go: assert property (shot_wr && !adc_integrate_o && !$past(adc_integrate_o) &&
      standby_pin_n_i && $past(standby_pin_n_i) && $past(standby_pin_n_i, 2) |->
      ##[1:2] adc_integrate_o)
    else $error("single shot did not start");
  a_hw_standby: assert property ((!standby_pin_n_i) [*5] |-> !adc_integrate_o)
    else $error("conversion runs in pin standby");
endmodule
bind rtc_seq rtc_seq_chk #(.PERIOD_CYC(PERIOD_CYC), .INTEG_CYC(INTEG_CYC)) chk_u (.clk_sys_i,
  .reset_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .prdata_o, .pready_o, .standby_pin_n_i,
  .fan_temp_o, .fan_temp_valid_o, .adc_integrate_o, .adc_gain_trim_o, .thermal_loop_open_o,
  .fan_loop_open_o);
`default_nettype wire

// ### testbench/rtc_diode_model.sv
// behavioural remote junction feeding the converter result port
// assumes the bench holds the wanted reading across each window
`timescale 1ns/1ps
`default_nettype none
module rtc_diode_model (
  input wire logic clk_sys_i,
  input wire logic adc_integrate_i,
  input wire rtc_pkg::rtc_temp_t temp_i,
  output var rtc_pkg::rtc_temp_t adc_result_o
);
  import rtc_pkg::*;
  logic tog_r = 1'b0;
  always_ff @(posedge clk_sys_i)
    tog_r <= ~tog_r;
  // reading over window
  // outside a window the value is meaningless, so it moves every cycle
  assign adc_result_o = adc_integrate_i ? temp_i : ~temp_i ^ {11{tog_r}};
endmodule
`default_nettype wire

// ### testbench/rtc_seq_tb.sv
// self-checking bench for the conversion sequencer
// assumes shortened counts and the behavioural junction model
`timescale 1ns/1ps
`default_nettype none
module rtc_seq_tb;
  import rtc_pkg::*;
  localparam int PER = 40;
  localparam int ITG = 10;
  localparam logic W = 1'b1;
  localparam logic R = 1'b0;
  typedef struct packed {logic rd; logic e; logic [31:0] d;} rtc_exp_t;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic [3:0] pstrb_i = 4'h0;
  logic standby_pin_n_i = 1'b1;
  rtc_temp_t temp = 11'h000;
  rtc_temp_t adc_result_i;
  rtc_temp_t fan_temp_o;
  logic [31:0] prdata_o;
  logic [3:0] adc_gain_trim_o;
  logic pready_o, pslverr_o, adc_integrate_o, fan_temp_valid_o;
  logic thermal_loop_open_o, fan_loop_open_o;
  int fails = 0;
  int comparisons = 0;
  rtc_exp_t bus_q[$];
  rtc_exp_t ex;
  rtc_temp_t fan_q[$];
  rtc_seq #(.PERIOD_CYC(PER), .INTEG_CYC(ITG)) dut_u (.clk_sys_i, .reset_n_i, .psel_i,
    .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o,
    .standby_pin_n_i, .adc_result_i, .adc_integrate_o, .adc_gain_trim_o, .fan_temp_o,
    .fan_temp_valid_o, .thermal_loop_open_o, .fan_loop_open_o);
  rtc_diode_model jct_u (.clk_sys_i, .adc_integrate_i(adc_integrate_o), .temp_i(temp),
    .adc_result_o(adc_result_i));
  initial
    forever #50 clk_sys_i = ~clk_sys_i;
  task automatic chk(input string what, input logic [31:0] x, input logic [31:0] got);
    comparisons++;
    if (got !== x)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, x, got);
    end
  endtask
  // lane0 always set, upper lanes random
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
      input logic [31:0] x, input logic e);
    int n;
    n = 0;
    bus_q.push_back({!wr, e, x});
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    pstrb_i <= {3'($urandom), 1'b1};
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    do @(posedge clk_sys_i); while (pready_o !== 1'b1 && ++n < 50);
    if (pready_o !== 1'b1)
      chk("pready", 32'h1, 32'(pready_o));
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic complete_run();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ------
  // result watcher
  // ------
  always @(posedge clk_sys_i)
  begin
    if (pready_o === 1'b1)
    begin
      ex = bus_q.pop_front();
      chk("pslverr", 32'(ex.e), 32'(pslverr_o));
      if (ex.rd && !ex.e)
        chk("prdata", ex.d, prdata_o);
    end
    if (fan_temp_valid_o === 1'b1)
      chk("fan_temp", fan_q.size() ? 32'(fan_q.pop_front()) : 32'hFFFF, 32'(fan_temp_o));
  end
  initial
  begin
    #400us;
    fails++;
    complete_run();
  end
  initial
  begin
    rtc_temp_t t;
    logic [31:0] v;
    logic [31:0] last;
    int n;
    last = 32'h0;
    void'($urandom(78));
    repeat (5) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    apb(R, 12'h000, 32'h0, 32'h0, 1'b0);
    apb(W, 12'h000, 32'h40, 32'h0, 1'b0);
    apb(R, 12'h00C, 32'h0, 32'h0, 1'b0);
    apb(W, 12'h00C, 32'h5, 32'h0, 1'b1);
    apb(R, 12'h018, 32'h0, 32'h0, 1'b1);
    repeat (4)
    begin
      v = $urandom & 32'h3F;
      apb(W, 12'h004, v, 32'h0, 1'b0);
      apb(R, 12'h004, 32'h0, v, 1'b0);
      chk("trim", 32'(v[5:2]), 32'(adc_gain_trim_o));
      chk("loops", 32'(v[1:0]), 32'({fan_loop_open_o, thermal_loop_open_o}));
    end
    $display("test registers done");
    for (int i = 0; i < 3; i++)
    begin
      t = (i == 0) ? 11'h3FF : (i == 1) ? 11'h400 : 11'($urandom);
      temp <= t;
      fan_q.push_back(t);
      apb(W, 12'h008, 32'h1, 32'h0, 1'b0);
      @(posedge clk_sys_i);
      chk("integrate", 32'h1, 32'(adc_integrate_o));
      apb(R, 12'h00C, 32'h0, last, 1'b0);
      apb(R, 12'h010, 32'h0, 32'h1, 1'b0);
      repeat (ITG + 4) @(posedge clk_sys_i);
      last = 32'(signed'(t));
      apb(R, 12'h00C, 32'h0, last, 1'b0);
      apb(R, 12'h014, 32'h0, {21'h000000, t}, 1'b0);
    end
    $display("test single shot done");
    standby_pin_n_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    apb(W, 12'h008, 32'h1, 32'h0, 1'b0);
    repeat (3) @(posedge clk_sys_i);
    chk("integrate", 32'h0, 32'(adc_integrate_o));
    apb(R, 12'h010, 32'h0, 32'h4, 1'b0);
    standby_pin_n_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    temp <= ~t;
    apb(W, 12'h008, 32'h1, 32'h0, 1'b0);
    repeat (2) @(posedge clk_sys_i);
    standby_pin_n_i <= 1'b0;
    repeat (ITG + 6) @(posedge clk_sys_i);
    apb(R, 12'h00C, 32'h0, last, 1'b0);
    standby_pin_n_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    $display("test standby done");
    t = 11'($urandom);
    temp <= t;
    fan_q.push_back(t);
    apb(W, 12'h000, 32'h0, 32'h0, 1'b0);
    n = 0;
    while (adc_integrate_o !== 1'b1 && n++ < 200) @(posedge clk_sys_i);
    chk("restart", 32'h1, 32'(n > PER - 4 && n < PER + 4));
    n = 0;
    while (adc_integrate_o === 1'b1 && n++ < 200) @(posedge clk_sys_i);
    temp <= ~t;
    while (adc_integrate_o !== 1'b1 && n++ < 200) @(posedge clk_sys_i);
    chk("period", 32'(PER), 32'(n));
    apb(W, 12'h000, 32'h40, 32'h0, 1'b0);
    repeat (PER + 10) @(posedge clk_sys_i);
    apb(R, 12'h00C, 32'h0, 32'(signed'(t)), 1'b0);
    $display("test periodic done");
    complete_run();
  end
endmodule
`default_nettype wire
